// ==== verilog/ddrc_pkg.sv ====
// Purpose: Shared constants and types of the DDR I/O cell.
// Assumes: 32-bit AXI4-Lite register bus.
// Notes: Offsets are byte addresses.
`default_nettype none
package ddrc_pkg;
    localparam int AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INV = 8'h04;
    localparam logic [7:0] OFS_PHASE = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;
    localparam logic [31:0] INV_RST = 32'h0000_0000;
    localparam logic [31:0] INV_MASK = 32'h0000_00FF;
    localparam logic [31:0] PHASE_RST = 32'h0000_0404;
    localparam logic [31:0] PHASE_MASK = 32'h0000_0F0F;
    localparam int C_BANK = 0;
    localparam int C_GRP = 2;
    localparam int C_NEGOE = 4;
    localparam int C_OELOW = 5;
    localparam int C_PUHI = 6;
    localparam int C_SCLR = 7;
    localparam int C_OCEUSE = 8;
    localparam int I_IOC = 0;
    localparam int I_DQS = 1;
    localparam int I_DQI = 2;
    localparam int I_TXD = 3;
    localparam int I_TXOE = 4;
    localparam int I_OCE = 5;
    localparam int I_ICE = 6;
    localparam int I_CLR = 7;
    localparam int P_TOP = 0;
    localparam int P_BOT = 8;
    localparam int S_DLYT = 8;
    localparam int S_DLYB = 16;
    localparam int PH_W = 4;
    localparam int PER_W = 8;
    localparam int DLY_DEPTH = 64;
    localparam int MEAS_REF = 4;
    localparam int SETTLE_MAX = 256;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;
    typedef enum logic [1:0] {DDRC_SIDE, DDRC_TOP, DDRC_BOT} ddrc_bank_e;
    typedef enum logic [1:0] {DDRC_X8, DDRC_X16, DDRC_X32} ddrc_grp_e;
endpackage : ddrc_pkg
`default_nettype wire

// ==== verilog/ddrc_psr_if.sv ====
// Purpose: Link between the cell and one phase-shift reference circuit.
// Assumes: Both ends run on clk_sys.
// Notes: dly is the common strobe delay in clk_sys cycles.
`timescale 1ns/10ps
`default_nettype none
interface ddrc_psr_if;
    logic ref_edge;
    logic [ddrc_pkg::PH_W-1:0] phase;
    logic [ddrc_pkg::PER_W-1:0] dly;
    logic locked;
    modport ref_side (input ref_edge, input phase, output dly, output locked);
    modport user (output ref_edge, output phase, input dly, input locked);
endinterface : ddrc_psr_if
`default_nettype wire

// ==== verilog/ddrc_phase_ref.sv ====
// Purpose: Phase-shift reference: measures the reference period, sets the delay.
// Assumes: ref_edge is a one-cycle pulse per reference clock rising edge.
// Notes: Phase is in sixteenths of a period.
`timescale 1ns/10ps
`default_nettype none
module ddrc_phase_ref (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    ddrc_psr_if.ref_side psr
);
    typedef enum logic {DDRC_ALIGN, DDRC_MEAS} ddrc_psr_e;
    localparam int PW = ddrc_pkg::PER_W;
    ddrc_psr_e st_r;
    logic [PW-1:0] cnt_r;
    logic [1:0] n_r;
    logic [ddrc_pkg::PH_W-1:0] ph_r;
    logic [PW-1:0] dly_r;
    logic locked_r;
    logic [PW+ddrc_pkg::PH_W-1:0] prod;
    logic [PW-1:0] per;

    // Period of the closing reference cycle, saturated.
    assign per = (cnt_r == {PW{1'b1}}) ? cnt_r : cnt_r + 1'b1;
    assign prod = per * ph_r;
    assign psr.dly = dly_r;
    assign psr.locked = locked_r;

    // Settle after MEAS_REF reference cycles, far inside SETTLE_MAX.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= DDRC_ALIGN;
            cnt_r <= '0;
            n_r <= '0;
            ph_r <= '0;
            dly_r <= '0;
            locked_r <= 1'b0;
        end else if (ce) begin
            if (psr.phase != ph_r) begin
                // Old delay stays applied until a fresh one is ready.
                ph_r <= psr.phase;
                locked_r <= 1'b0;
                st_r <= DDRC_ALIGN;
            end else begin
                case (st_r)
                    DDRC_ALIGN: begin
                        if (psr.ref_edge) begin
                            st_r <= DDRC_MEAS;
                            cnt_r <= '0;
                            n_r <= '0;
                        end
                    end
                    DDRC_MEAS: begin
                        if (psr.ref_edge) begin
                            cnt_r <= '0;
                            n_r <= n_r + 1'b1;
                            if (n_r == 2'(ddrc_pkg::MEAS_REF - 1)) begin
                                dly_r <= prod[PW+ddrc_pkg::PH_W-1:ddrc_pkg::PH_W];
                                locked_r <= 1'b1;
                            end
                        end else if (cnt_r != {PW{1'b1}}) begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    default: st_r <= DDRC_ALIGN;
                endcase
            end
        end
    end
endmodule : ddrc_phase_ref
`default_nettype wire

// ==== verilog/ddrc_io_cell.sv ====
// Purpose: DDR I/O cell group with strobe delay, sampled on clk_sys.
// Assumes: io clock, strobe, reference clocks and pins are asynchronous.
// Notes: Rules below.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module ddrc_io_cell #(
    parameter int DQ_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic io_clk_pin,
    input wire logic ref_clk_top,
    input wire logic ref_clk_bot,
    input wire logic dqs_pin,
    input wire logic register_clear_preset_input_b,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic [DQ_W-1:0] dq_oe,
    input wire logic [DQ_W-1:0] tx_a,
    input wire logic [DQ_W-1:0] tx_b,
    input wire logic tx_oe,
    input wire logic out_ce,
    input wire logic in_ce,
    output logic [DQ_W-1:0] rx_hi,
    output logic [DQ_W-1:0] rx_lo,
    output logic rx_valid
);
    localparam int SW = DQ_W + 5;
    logic [1:0] rst_sync_r, bresp_r, rresp_r, bank;
    logic [SW-1:0] syn1_r, syn2_r;
    logic [31:0] ctrl_r, inv_r, phase_r, w_data_r, rdata_r, stat;
    logic [7:0] aw_addr_r;
    logic [3:0] w_strb_r;
    logic rst_n, aw_full_r, w_full_r, bvalid_r, rvalid_r, do_wr;
    ddrc_psr_if psr_t ();
    ddrc_psr_if psr_b ();
    logic [ddrc_pkg::DLY_DEPTH-1:0] stb_line_r;
    logic ioc_prev_r, stb_prev_r, ioc_lvl, stb_lvl, ref_t_prev_r, ref_b_prev_r;
    logic [ddrc_pkg::PER_W-1:0] dly_sel;
    logic [DQ_W-1:0] ded, rise_v, fall_v, hi_v, dq_in, cap_a_r, cap_b_r, latch_r;
    logic [DQ_W-1:0] rx_hi_r, rx_lo_r, out_a_r, out_b_r, dq_o_r, dq_oe_r, pv;
    logic rx_valid_r, oe_pos_r, oe_neg_r, ioc_rise, ioc_fall, stb_rise, stb_fall;
    logic oce, ice, init, oe_pin;
    int gw;

    // Two-flop reset release, so all flops leave reset together.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Two-flop synchronisers for every pin and foreign clock.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syn1_r <= '0;
            syn2_r <= '0;
        end else if (ce) begin
            syn1_r <= {register_clear_preset_input_b, ref_clk_bot, ref_clk_top,
                       dqs_pin, io_clk_pin, dq_i};
            syn2_r <= syn1_r;
        end
    end

    // Per-input inversion at the cell boundary.
    assign ioc_lvl = syn2_r[DQ_W] ^ inv_r[ddrc_pkg::I_IOC];
    assign dq_in = syn2_r[DQ_W-1:0] ^ {DQ_W{inv_r[ddrc_pkg::I_DQI]}};
    assign init = ctrl_r[ddrc_pkg::C_SCLR] |
                  ~(syn2_r[DQ_W+4] ^ inv_r[ddrc_pkg::I_CLR]);
    assign pv = {DQ_W{ctrl_r[ddrc_pkg::C_PUHI]}};
    // An unused output clock enable reads as high.
    assign oce = ~ctrl_r[ddrc_pkg::C_OCEUSE] | (out_ce ^ inv_r[ddrc_pkg::I_OCE]);
    assign ice = in_ce ^ inv_r[ddrc_pkg::I_ICE];
    assign bank = ctrl_r[ddrc_pkg::C_BANK+:2];

    // One reference circuit each for the top and bottom device edges.
    assign psr_t.ref_edge = syn2_r[DQ_W+2] & ~ref_t_prev_r;
    assign psr_b.ref_edge = syn2_r[DQ_W+3] & ~ref_b_prev_r;
    assign psr_t.phase = phase_r[ddrc_pkg::P_TOP+:ddrc_pkg::PH_W];
    assign psr_b.phase = phase_r[ddrc_pkg::P_BOT+:ddrc_pkg::PH_W];

    ddrc_phase_ref u_ref_top (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .psr(psr_t.ref_side)
    );

    ddrc_phase_ref u_ref_bot (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .psr(psr_b.ref_side)
    );

    // The strobe delay is a tapped line; the tap is clamped to its depth.
    always_comb begin
        dly_sel = (bank == ddrc_pkg::DDRC_BOT) ? psr_b.dly : psr_t.dly;
        if (dly_sel > ddrc_pkg::PER_W'(ddrc_pkg::DLY_DEPTH - 1)) begin
            dly_sel = ddrc_pkg::PER_W'(ddrc_pkg::DLY_DEPTH - 1);
        end
    end
    assign stb_lvl = stb_line_r[dly_sel[5:0]];

    // Edge history for the io clock, delayed strobe and reference clocks.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stb_line_r <= '0;
            ioc_prev_r <= 1'b0;
            stb_prev_r <= 1'b0;
            ref_t_prev_r <= 1'b0;
            ref_b_prev_r <= 1'b0;
        end else if (ce) begin
            stb_line_r <= {stb_line_r[ddrc_pkg::DLY_DEPTH-2:0],
                           syn2_r[DQ_W+1] ^ inv_r[ddrc_pkg::I_DQS]};
            ioc_prev_r <= ioc_lvl;
            stb_prev_r <= stb_lvl;
            ref_t_prev_r <= syn2_r[DQ_W+2];
            ref_b_prev_r <= syn2_r[DQ_W+3];
        end
    end
    assign ioc_rise = ioc_lvl & ~ioc_prev_r;
    assign ioc_fall = ~ioc_lvl & ioc_prev_r;
    assign stb_rise = stb_lvl & ~stb_prev_r;
    assign stb_fall = ~stb_lvl & stb_prev_r;

    // Strobe-group lanes of top or bottom banks take the strobe.
    always_comb begin
        case (ctrl_r[ddrc_pkg::C_GRP+:2])
            ddrc_pkg::DDRC_X16: gw = 16;
            ddrc_pkg::DDRC_X32: gw = 32;
            default: gw = 8;
        endcase
        for (int i = 0; i < DQ_W; i++) begin
            ded[i] = (bank != ddrc_pkg::DDRC_SIDE) && (i < gw);
            rise_v[i] = ded[i] ? stb_rise : ioc_rise;
            fall_v[i] = ded[i] ? stb_fall : ioc_fall;
            hi_v[i] = ded[i] ? stb_lvl : ioc_lvl;
        end
    end

    // Rising and falling capture, latch, then the paired output.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_a_r <= '0;
            cap_b_r <= '0;
            latch_r <= '0;
            rx_hi_r <= '0;
            rx_lo_r <= '0;
            rx_valid_r <= 1'b0;
        end else if (ce) begin
            if (init) begin
                cap_a_r <= pv;
                cap_b_r <= pv;
                latch_r <= pv;
                rx_hi_r <= pv;
                rx_lo_r <= pv;
                rx_valid_r <= 1'b0;
            end else if (ice) begin
                cap_a_r <= (cap_a_r & ~rise_v) | (dq_in & rise_v);
                cap_b_r <= (cap_b_r & ~fall_v) | (dq_in & fall_v);
                latch_r <= (latch_r & ~hi_v) | (cap_a_r & hi_v);
                rx_hi_r <= (rx_hi_r & ~rise_v) | (latch_r & rise_v);
                rx_lo_r <= (rx_lo_r & ~rise_v) | (cap_b_r & rise_v);
                rx_valid_r <= |rise_v;
            end else begin
                rx_valid_r <= 1'b0;
            end
        end
    end

    // Output and enable registers share the io clock and one clock enable.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_a_r <= '0;
            out_b_r <= '0;
            oe_pos_r <= 1'b0;
            oe_neg_r <= 1'b0;
        end else if (ce) begin
            if (init) begin
                out_a_r <= pv;
                out_b_r <= pv;
                oe_pos_r <= ctrl_r[ddrc_pkg::C_PUHI];
                oe_neg_r <= ctrl_r[ddrc_pkg::C_PUHI];
            end else if (oce) begin
                if (ioc_rise) begin
                    out_a_r <= tx_a ^ {DQ_W{inv_r[ddrc_pkg::I_TXD]}};
                    out_b_r <= tx_b ^ {DQ_W{inv_r[ddrc_pkg::I_TXD]}};
                    oe_pos_r <= tx_oe ^ inv_r[ddrc_pkg::I_TXOE];
                end
                if (ioc_fall) begin
                    oe_neg_r <= oe_pos_r;
                end
            end
        end
    end

    // Enable polarity is applied last, after the edge choice.
    assign oe_pin = (ctrl_r[ddrc_pkg::C_NEGOE] ? oe_neg_r : oe_pos_r)
                    ^ ctrl_r[ddrc_pkg::C_OELOW];

    // The io clock level picks the bit, so two bits go per period.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dq_o_r <= '0;
            dq_oe_r <= '0;
        end else if (ce) begin
            dq_o_r <= ioc_lvl ? out_a_r : out_b_r;
            dq_oe_r <= {DQ_W{oe_pin}};
        end
    end

    // Write address and data are taken in either order, then answered.
    assign s_axi_awready = ce & ~aw_full_r;
    assign s_axi_wready = ce & ~w_full_r;
    assign do_wr = ce & aw_full_r & w_full_r & ~bvalid_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= ddrc_pkg::RESP_OK;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_r) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                case ({aw_addr_r[7:2], 2'h0})
                    ddrc_pkg::OFS_CTRL, ddrc_pkg::OFS_INV, ddrc_pkg::OFS_PHASE,
                    ddrc_pkg::OFS_STAT: bresp_r <= ddrc_pkg::RESP_OK;
                    default: bresp_r <= ddrc_pkg::RESP_DEC;
                endcase
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Register writes honour byte strobes; reserved bits are never stored.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= ddrc_pkg::CTRL_RST;
            inv_r <= ddrc_pkg::INV_RST;
            phase_r <= ddrc_pkg::PHASE_RST;
        end else if (ce && do_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_r[b]) begin
                    case ({aw_addr_r[7:2], 2'h0})
                        ddrc_pkg::OFS_CTRL: ctrl_r[8*b+:8] <=
                            w_data_r[8*b+:8] & ddrc_pkg::CTRL_MASK[8*b+:8];
                        ddrc_pkg::OFS_INV: inv_r[8*b+:8] <=
                            w_data_r[8*b+:8] & ddrc_pkg::INV_MASK[8*b+:8];
                        ddrc_pkg::OFS_PHASE: phase_r[8*b+:8] <=
                            w_data_r[8*b+:8] & ddrc_pkg::PHASE_MASK[8*b+:8];
                        default: ;
                    endcase
                end
            end
        end
    end

    // Status shows both reference circuits' lock and delay.
    always_comb begin
        stat = '0;
        stat[0] = psr_t.locked;
        stat[1] = psr_b.locked;
        stat[ddrc_pkg::S_DLYT+:ddrc_pkg::PER_W] = psr_t.dly;
        stat[ddrc_pkg::S_DLYB+:ddrc_pkg::PER_W] = psr_b.dly;
    end

    // Reads answer one cycle after the address is taken.
    assign s_axi_arready = ce & ~rvalid_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= ddrc_pkg::RESP_OK;
        end else if (ce) begin
            if (s_axi_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rresp_r <= ddrc_pkg::RESP_OK;
                case ({s_axi_araddr[7:2], 2'h0})
                    ddrc_pkg::OFS_CTRL: rdata_r <= ctrl_r;
                    ddrc_pkg::OFS_INV: rdata_r <= inv_r;
                    ddrc_pkg::OFS_PHASE: rdata_r <= phase_r;
                    ddrc_pkg::OFS_STAT: rdata_r <= stat;
                    default: begin
                        rdata_r <= '0;
                        rresp_r <= ddrc_pkg::RESP_DEC;
                    end
                endcase
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign dq_o = dq_o_r;
    assign dq_oe = dq_oe_r;
    assign rx_hi = rx_hi_r;
    assign rx_lo = rx_lo_r;
    assign rx_valid = rx_valid_r;
endmodule : ddrc_io_cell
`default_nettype wire

// ==== tb/ddrc_io_cell_sva.sv ====
// Purpose: Port checks of the DDR I/O cell.
// Assumes: One clk_sys domain; rst_b is active low.
// Notes: Attached by the bind below.
`timescale 1ns/10ps
`default_nettype none
module ddrc_io_cell_sva #(
    parameter int DQ_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DQ_W-1:0] dq_oe,
    input wire logic rx_valid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // Taken requests are answered in fixed time.
    b_resp_a: assert property (!s_axi_bvalid && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    r_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // Answers stand until taken.
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    // Only one write and one read may be under way.
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    aw_busy_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready && !s_axi_wready) else $error("write taken twice");
    // One enable turns all lanes.
    oe_whole_a: assert property (dq_oe == '0 || dq_oe == '1)
        else $error("lane enables differ");
    // A presented pair is flagged for one cycle.
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("pair flag too long");
    wr_c: cover property (s_axi_bvalid && s_axi_bready);
    rd_c: cover property (s_axi_rvalid && s_axi_rready);
    rx_c: cover property (rx_valid);
endmodule : ddrc_io_cell_sva
bind ddrc_io_cell ddrc_io_cell_sva #(.DQ_W(DQ_W)) u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .dq_oe(dq_oe), .rx_valid(rx_valid));
`default_nettype wire

// ==== tb/ddrc_mem_model.sv ====
// Purpose: Memory side: reference clocks and read bursts.
// Assumes: ck is the io clock as the memory sees it.
// Notes: Strobe rests low and data hold outside bursts.
`timescale 1ns/10ps
`default_nettype none
module ddrc_mem_model (
    input wire logic ck,
    input wire logic go,
    input wire logic [31:0] d_hi,
    input wire logic [31:0] d_lo,
    output logic dqs,
    output logic [31:0] dq,
    output logic ref_top,
    output logic ref_bot
);
    initial {dqs, dq, ref_top, ref_bot} = 35'h0;
    // Reference clocks run at the strobe rate; ref_top is skewed so no edge meets clk_sys, but ref_bot edges fall on clk_sys edges.
    always @(ck) ref_top <= #3 ck;
    always @(ck) ref_bot <= #5 ck;
    // Six edge-aligned strobe cycles, then the data lines are driven to ~d_lo.
    always @(posedge ck) begin
        if (go) begin
            repeat (6) begin
                #40;
                dqs = 1'b1;
                dq = d_hi;
                #80;
                dqs = 1'b0;
                dq = d_lo;
                @(posedge ck);
            end
            #40;
            dq = ~d_lo;
        end
    end
endmodule : ddrc_mem_model
`default_nettype wire

// ==== tb/ddrc_io_cell_tb_top.sv ====
// Purpose: Self-checking bench of the DDR I/O cell.
// Assumes: Io clock 160 ns, clk_sys 8 ns.
// Notes: Pins resolve from the cell enable and the memory model.
`timescale 1ns/10ps
`default_nettype none
module ddrc_io_cell_tb_top;
    localparam logic [31:0] D_HI = 32'hA5C3_0F96;
    localparam logic [31:0] D_LO = 32'h5A3C_F069;
    localparam int PER = 20;
    logic clk_sys = 1'b0;
    logic io_clk = 1'b0;
    logic rst_b, go, tx_oe, out_ce, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, rxv;
    logic dqs, ref_t, ref_b;
    logic [7:0] awa, ara;
    logic [1:0] br, rr;
    logic [31:0] wd, rd_d, tx_a, tx_b, dq_o, dq_oe, dq_i, mem_dq, rx_hi, rx_lo;
    int errors = 0;
    int samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    // The io clock starts off phase so its edges never meet clk_sys edges.
    initial begin
        #3;
        forever #80 io_clk = ~io_clk;
    end
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & mem_dq);
    ddrc_io_cell #(.DQ_W(32)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .io_clk_pin(io_clk), .ref_clk_top(ref_t), .ref_clk_bot(ref_b),
        .dqs_pin(dqs), .register_clear_preset_input_b(1'b1), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe), .tx_a(tx_a), .tx_b(tx_b), .tx_oe(tx_oe), .out_ce(out_ce),
        .in_ce(1'b1), .rx_hi(rx_hi), .rx_lo(rx_lo), .rx_valid(rxv));
    ddrc_mem_model u_mem (.ck(io_clk), .go(go), .d_hi(D_HI), .d_lo(D_LO), .dqs(dqs),
        .dq(mem_dq), .ref_top(ref_t), .ref_bot(ref_b));
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic limit(input logic hit);
        if (hit) begin
            errors++;
            final_report();
        end
    endtask : limit
    // Ready is looked at mid-cycle, so the edge that takes it is never raced.
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic [1:0] r);
        logic [4:0] tk;
        int n;
        n = 0;
        tk = 5'h0;
        @(posedge clk_sys);
        awa <= a;
        ara <= a;
        wd <= d;
        {awv, wv, bry, arv, rry} <= w ? 5'h1C : 5'h03;
        while (!(tk[2] || tk[0]) && n < 600) begin
            @(negedge clk_sys);
            tk = {awv & awr, wv & wrd, bv & bry, arv & arr, rv & rry};
            q = rd_d;
            r = w ? br : rr;
            @(posedge clk_sys);
            {awv, wv, bry, arv, rry} <= {awv, wv, bry, arv, rry} & ~tk;
            n++;
        end
        limit(n >= 600);
    endtask : axi
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        axi(1'b1, a, d, q, r);
    endtask : wr
    // Returns 64 ns after the io clock reaches the given level.
    task automatic wait_io(input logic lvl);
        int n;
        n = 0;
        while (io_clk == lvl && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        while (io_clk != lvl && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        limit(n >= 60);
        repeat (8) @(posedge clk_sys);
    endtask : wait_io
    task automatic lock(input logic [1:0] m, output logic [31:0] q);
        logic [1:0] r;
        int n;
        n = 0;
        q = 32'h0;
        while ((q[1:0] & m) != m && n < 1400) begin
            axi(1'b0, ddrc_pkg::OFS_STAT, 32'h0, q, r);
            n++;
        end
        limit(n >= 1400);
    endtask : lock
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        logic [31:0] m;
        logic [31:0] rtab [3] = '{ddrc_pkg::CTRL_RST, ddrc_pkg::INV_RST, ddrc_pkg::PHASE_RST};
        logic [31:0] ctab [5] = '{32'h0, 32'h1, 32'h5, 32'h9, 32'h6};
        logic [31:0] mtab [5] = '{32'h0, 32'hFF, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFF};
        {rst_b, awv, wv, bry, arv, rry, go, tx_oe, out_ce} = 9'h1;
        {awa, ara, wd, tx_a, tx_b} = 112'h0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Reset values, then an unmapped word.
        for (int i = 0; i < 4; i++) begin
            axi(1'b0, (i == 3) ? 8'h10 : 8'(i * 4), 32'h0, q, r);
            chk(q, (i == 3) ? 32'h0 : rtab[i]);
            chk(32'(r), 32'((i == 3) ? ddrc_pkg::RESP_DEC : ddrc_pkg::RESP_OK));
        end
        wr(ddrc_pkg::OFS_CTRL, 32'h1);
        lock(2'h3, q);
        chk({16'h0, q[23:8]}, 32'((PER * 4 / 16) * 257));
        // Each bank and group mode: strobe lanes keep order, io lanes see it turned.
        for (int i = 0; i < 5; i++) begin
            wr(ddrc_pkg::OFS_CTRL, ctab[i]);
            go <= 1'b1;
            wait_io(1'b1);
            go <= 1'b0;
            repeat (3) wait_io(1'b1);
            m = mtab[i];
            chk(rx_hi, (D_HI & m) | (D_LO & ~m));
            chk(rx_lo, (D_LO & m) | (D_HI & ~m));
            repeat (4) wait_io(1'b1);
        end
        // Launch: first bit while io clock high, second while low.
        wr(ddrc_pkg::OFS_CTRL, 32'h0);
        {tx_a, tx_b, tx_oe} <= {D_HI, D_LO, 1'b1};
        repeat (2) wait_io(1'b1);
        chk(dq_o, D_HI);
        chk(dq_oe, 32'hFFFF_FFFF);
        wait_io(1'b0);
        chk(dq_o, D_LO);
        wr(ddrc_pkg::OFS_INV, 32'h8);
        repeat (2) wait_io(1'b1);
        chk(dq_o, ~D_HI);
        wr(ddrc_pkg::OFS_INV, 32'h0);
        repeat (2) wait_io(1'b1);
        wr(ddrc_pkg::OFS_CTRL, 32'h100);
        {out_ce, tx_a} <= {1'b0, D_LO};
        repeat (2) wait_io(1'b1);
        chk(dq_o, D_HI);
        out_ce <= 1'b1;
        wr(ddrc_pkg::OFS_CTRL, 32'h20);
        wait_io(1'b1);
        chk(dq_oe, 32'h0);
        // The falling-edge enable register holds turn-on back half a cycle.
        wr(ddrc_pkg::OFS_CTRL, 32'h10);
        tx_oe <= 1'b0;
        wait_io(1'b1);
        tx_oe <= 1'b1;
        wait_io(1'b1);
        chk(dq_oe, 32'h0);
        wait_io(1'b0);
        chk(dq_oe, 32'hFFFF_FFFF);
        // A new bottom phase keeps the old delay until it has settled.
        wr(ddrc_pkg::OFS_PHASE, 32'h0804);
        axi(1'b0, ddrc_pkg::OFS_STAT, 32'h0, q, r);
        chk({24'h0, q[23:16]}, 32'(PER * 4 / 16));
        lock(2'h2, q);
        chk({16'h0, q[23:8]}, 32'((PER * 8 / 16) * 256 + PER * 4 / 16));
        final_report();
    end
endmodule : ddrc_io_cell_tb_top
`default_nettype wire
